// file: core/uetc_pkg.sv
// Constants, register map and types for the endpoint transaction block.
// Assumes one AHB-Lite master and a serial engine that delivers decoded tokens.
package uetc_pkg;
	localparam int N_EP  = 4;   // Endpoints served
	localparam int EPW   = 2;   // Endpoint number width
	localparam int DEPTH = 32;  // Bytes per bank
	localparam int PTRW  = 5;   // Byte index width inside a bank
	localparam int LENW  = 6;   // Length width, counts up to DEPTH
	localparam int CNTW  = 11;  // Host byte count width
	// Register byte offsets
	localparam logic [7:0] OFF_SEL  = 8'h00;
	localparam logic [7:0] OFF_CTRL = 8'h04;
	localparam logic [7:0] OFF_STAT = 8'h08;
	localparam logic [7:0] OFF_DATA = 8'h0c;
	localparam logic [7:0] OFF_BCL  = 8'h10;
	localparam logic [7:0] OFF_BCH  = 8'h14;
	// Status register bits
	localparam int ST_TXC = 0;  // tx_complete_flag
	localparam int ST_RX0 = 1;  // out_bank0_received_flag
	localparam int ST_SET = 2;  // setup_received_flag
	localparam int ST_RDY = 4;  // tx_ready_flag
	localparam int ST_CRC = 3;  // stall_or_crc_error_flag
	localparam int ST_DIR = 7;  // Control data stage direction
	// Control register bits
	localparam int CT_EN  = 7;
	localparam int CT_PP  = 3;  // Ping-pong enable
	localparam int CT_DIR = 2;  // 1 = IN
	localparam logic [1:0] TY_CTRL = 2'h0;
	localparam logic [1:0] TY_ISO  = 2'h1;
	localparam logic [7:0] CTRL_EP0_RST = 8'h80;
	localparam logic [7:0] CTRL_RST     = 8'h00;
	// Token kinds from the serial engine
	localparam logic [1:0] TK_OUT   = 2'h0;
	localparam logic [1:0] TK_IN    = 2'h1;
	localparam logic [1:0] TK_SETUP = 2'h2;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	typedef enum logic [1:0] {S_IDLE, S_RX, S_TX, S_ACKW} uetc_state_t;
endpackage : uetc_pkg

// file: core/uetc_core.sv
// Endpoint transaction control: flags, FIFOs and token answers.
// Assumes a serial engine that decodes tokens and streams bytes at hclk.
//
// The implementer's own choices: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module uetc_core import uetc_pkg::*; (
	input  wire logic            hclk,
	input  wire logic            hresetn,
	input  wire logic            ce,
	input  wire logic            hsel,
	input  wire logic [31:0]     haddr,
	input  wire logic [1:0]      htrans,
	input  wire logic            hwrite,
	input  wire logic [2:0]      hsize,
	input  wire logic [31:0]     hwdata,
	input  wire logic            hready,
	output logic                 hreadyout,
	output logic                 hresp,
	output logic [31:0]          hrdata,
	input  wire logic            tok_valid,
	input  wire logic [1:0]      tok_kind,
	input  wire logic [EPW-1:0]  tok_ep,
	input  wire logic            rx_valid,
	input  wire logic [7:0]      rx_data,
	input  wire logic            rx_end,
	input  wire logic            rx_crc_ok,
	input  wire logic            host_ack,
	output logic                 tx_valid,
	output logic [7:0]           tx_data,
	output logic                 tx_last,
	output logic                 tx_zlp,
	output logic                 hs_ack,
	output logic                 hs_nak
);
	logic [7:0]      fifo_mem [N_EP*2*DEPTH];  // Two banks per endpoint
	logic [EPW-1:0]  sel_reg;                  // endpoint_select_reg
	logic [7:0]      ctrl_reg  [N_EP];
	logic [N_EP-1:0] txc_reg, rx0_reg, set_reg, crc_reg, dir_reg;
	logic [1:0]      full_reg  [N_EP];         // Bank handed to USB side
	logic [LENW-1:0] len_reg   [N_EP][2];      // Packet length per bank
	logic [N_EP-1:0] fwb_reg, usbb_reg;        // Firmware / USB bank
	logic [LENW-1:0] wrp_reg   [N_EP];         // Firmware write index
	logic [LENW-1:0] rdp_reg   [N_EP];         // Firmware read index
	logic [CNTW-1:0] bcnt_reg  [N_EP];
	logic            dwr_reg;                  // Data phase is a write
	logic [7:0]      dadr_reg;
	uetc_state_t     state_reg;
	logic [EPW-1:0]  cep_reg;                  // Endpoint in flight
	logic [1:0]      ckind_reg;
	logic            nakp_reg;                 // OUT refused at token time
	logic [CNTW-1:0] rxt_reg;                  // Bytes sent by host
	logic [LENW-1:0] rxs_reg;                  // Bytes stored
	logic [LENW-1:0] txi_reg, txl_reg;

	// Flat FIFO index, used by firmware and USB side alike
	function automatic logic [7:0] fidx(logic [EPW-1:0] e, logic b, logic [LENW-1:0] p);
		fidx = {e, b, p[PTRW-1:0]};
	endfunction : fidx

	// Status byte as firmware sees it
	function automatic logic [7:0] stat_of(logic [EPW-1:0] e);
		stat_of = 8'h00;
		stat_of[ST_TXC] = txc_reg[e];
		stat_of[ST_RX0] = rx0_reg[e];
		stat_of[ST_SET] = set_reg[e];
		stat_of[ST_CRC] = crc_reg[e];
		stat_of[ST_RDY] = full_reg[e][fwb_reg[e]];
		stat_of[ST_DIR] = dir_reg[e];
	endfunction : stat_of

	// Bus decode
	logic ahb_go, rd_go;
	logic w_sel, w_ctrl, w_stat, w_data, r_data;
	logic [7:0] wd;
	assign ahb_go = hsel & (htrans == HTRANS_NONSEQ) & hready & ce;
	assign rd_go  = ahb_go & ~hwrite;
	assign wd     = hwdata[7:0];
	assign w_sel  = dwr_reg & ce & (dadr_reg == OFF_SEL);
	assign w_ctrl = dwr_reg & ce & (dadr_reg == OFF_CTRL);
	assign w_stat = dwr_reg & ce & (dadr_reg == OFF_STAT);
	assign w_data = dwr_reg & ce & (dadr_reg == OFF_DATA);
	assign r_data = rd_go & (haddr[7:0] == OFF_DATA);
	// Stalling on a frozen clock keeps the master from losing a beat
	assign hreadyout = ce;
	assign hresp     = 1'b0;

	// Endpoint type checks for the token in flight
	logic is_ctrl, is_iso, ep_en, in_ok, out_ok;
	assign is_ctrl = ctrl_reg[tok_ep][1:0] == TY_CTRL;
	assign is_iso  = ctrl_reg[cep_reg][1:0] == TY_ISO;
	assign ep_en   = ctrl_reg[tok_ep][CT_EN];
	assign in_ok   = ep_en & (is_ctrl | ctrl_reg[tok_ep][CT_DIR]);
	assign out_ok  = ep_en & (is_ctrl | ~ctrl_reg[tok_ep][CT_DIR]);

	// USB side events, one cycle each
	logic ev_txdone, ev_setup, ev_out, ev_iso, rx_store;
	assign ev_txdone = (state_reg == S_ACKW) & host_ack & ce;
	assign ev_setup  = (state_reg == S_RX) & rx_end & ce & (ckind_reg == TK_SETUP) & rx_crc_ok;
	assign ev_out    = (state_reg == S_RX) & rx_end & ce & (ckind_reg == TK_OUT)
		& ~is_iso & ~nakp_reg & rx_crc_ok;
	// Iso sets its flag only when the bank is free, whatever the CRC
	assign ev_iso    = (state_reg == S_RX) & rx_end & ce & (ckind_reg == TK_OUT)
		& is_iso & ~rx0_reg[cep_reg];
	// Overflow bytes are counted but never stored
	assign rx_store  = (state_reg == S_RX) & rx_valid & ce & (rxs_reg < LENW'(DEPTH))
		& ((ckind_reg == TK_SETUP)
		| (is_iso ? ~rx0_reg[cep_reg] : ~nakp_reg));

	// AHB address phase capture
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			dwr_reg  <= 1'b0;
			dadr_reg <= 8'h00;
		end else if (ce) begin
			dwr_reg  <= ahb_go & hwrite;
			dadr_reg <= haddr[7:0];
		end
	end

	// Read data, taken at address phase so it stands for the data phase
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_go) begin
			case (haddr[7:0])
				OFF_SEL:  hrdata <= {30'h0, sel_reg};
				OFF_CTRL: hrdata <= {24'h0, ctrl_reg[sel_reg]};
				OFF_STAT: hrdata <= {24'h0, stat_of(sel_reg)};
				OFF_DATA: hrdata <= {24'h0, fifo_mem[fidx(sel_reg, 1'b0, rdp_reg[sel_reg])]};
				OFF_BCL:  hrdata <= {24'h0, bcnt_reg[sel_reg][7:0]};
				OFF_BCH:  hrdata <= {29'h0, bcnt_reg[sel_reg][CNTW-1:8]};
				default:  hrdata <= 32'h0000_0000;  // Unmapped reads zero
			endcase
		end
	end

	// Endpoint select and configuration
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			sel_reg <= '0;
			for (int e = 0; e < N_EP; e++) begin
				ctrl_reg[e] <= (e == 0) ? CTRL_EP0_RST : CTRL_RST;
			end
		end else begin
			if (w_sel) begin
				sel_reg <= wd[EPW-1:0];
			end
			// Endpoint 0 stays an enabled control endpoint
			if (w_ctrl && sel_reg != '0) begin
				ctrl_reg[sel_reg] <= wd;
			end
		end
	end

	// FIFO storage: firmware fills IN banks, USB side fills bank 0 on OUT
	always_ff @(posedge hclk) begin
		if (w_data && wrp_reg[sel_reg] < LENW'(DEPTH)) begin
			fifo_mem[fidx(sel_reg, fwb_reg[sel_reg], wrp_reg[sel_reg])] <= wd;
		end
		if (rx_store) begin
			fifo_mem[fidx(cep_reg, 1'b0, rxs_reg)] <= rx_data;
		end
	end

	// Per-endpoint flags, banks and pointers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			txc_reg  <= '0;
			rx0_reg  <= '0;
			set_reg  <= '0;
			crc_reg  <= '0;
			dir_reg  <= '0;
			fwb_reg  <= '0;
			usbb_reg <= '0;
			for (int e = 0; e < N_EP; e++) begin
				full_reg[e] <= 2'h0;
				len_reg[e][0] <= '0;
				len_reg[e][1] <= '0;
				wrp_reg[e]  <= '0;
				rdp_reg[e]  <= '0;
				bcnt_reg[e] <= '0;
			end
		end else if (ce) begin
			for (int e = 0; e < N_EP; e++) begin
				// Firmware side first; hardware sets below override it
				if (w_stat && sel_reg == EPW'(e)) begin
					txc_reg[e] <= txc_reg[e] & wd[ST_TXC];
					rx0_reg[e] <= rx0_reg[e] & wd[ST_RX0];
					set_reg[e] <= set_reg[e] & wd[ST_SET];
					crc_reg[e] <= crc_reg[e] & wd[ST_CRC];
					dir_reg[e] <= wd[ST_DIR];
					// Freed receive FIFO restarts at byte zero
					if ((rx0_reg[e] & ~wd[ST_RX0]) | (set_reg[e] & ~wd[ST_SET])) begin
						rdp_reg[e] <= '0;
					end
					if (wd[ST_RDY] && !full_reg[e][fwb_reg[e]]) begin
						full_reg[e][fwb_reg[e]] <= 1'b1;
						len_reg[e][fwb_reg[e]]  <= wrp_reg[e];
						wrp_reg[e] <= '0;
						if (ctrl_reg[e][CT_PP]) begin
							fwb_reg[e] <= ~fwb_reg[e];
						end
					end else if (!wd[ST_RDY] && full_reg[e][fwb_reg[e]]
						&& !ctrl_reg[e][CT_PP]) begin
						full_reg[e][fwb_reg[e]] <= 1'b0;
						wrp_reg[e] <= '0;
					end
				end
				if (w_data && sel_reg == EPW'(e) && wrp_reg[e] < LENW'(DEPTH)) begin
					wrp_reg[e] <= wrp_reg[e] + LENW'(1);
				end
				if (r_data && sel_reg == EPW'(e)) begin
					rdp_reg[e] <= rdp_reg[e] + LENW'(1);
				end
				if (cep_reg == EPW'(e)) begin
					if (ev_txdone) begin
						txc_reg[e] <= 1'b1;
						full_reg[e][usbb_reg[e]] <= 1'b0;
						if (ctrl_reg[e][CT_PP]) begin
							usbb_reg[e] <= ~usbb_reg[e];
						end
					end
					if (ev_out | ev_iso) begin
						rx0_reg[e]  <= 1'b1;
						bcnt_reg[e] <= rxt_reg;
						rdp_reg[e]  <= '0;
					end
					if (ev_iso) begin
						crc_reg[e] <= ~rx_crc_ok;
					end
					if (ev_setup) begin
						set_reg[e]  <= 1'b1;
						txc_reg[e]  <= 1'b0;
						rx0_reg[e]  <= 1'b0;
						crc_reg[e]  <= 1'b0;
						dir_reg[e]  <= 1'b0;
						full_reg[e] <= 2'h0;
						bcnt_reg[e] <= rxt_reg;
						rdp_reg[e]  <= '0;
					end
				end
			end
		end
	end

	// Token sequencer
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= S_IDLE;
			cep_reg   <= '0;
			ckind_reg <= TK_OUT;
			nakp_reg  <= 1'b0;
			rxt_reg   <= '0;
			rxs_reg   <= '0;
			txi_reg   <= '0;
			txl_reg   <= '0;
		end else if (ce) begin
			case (state_reg)
				S_IDLE: begin
					rxt_reg <= '0;
					rxs_reg <= '0;
					txi_reg <= '0;
					if (tok_valid) begin
						cep_reg   <= tok_ep;
						ckind_reg <= tok_kind;
						nakp_reg  <= rx0_reg[tok_ep];
						if (tok_kind == TK_IN && in_ok && full_reg[tok_ep][usbb_reg[tok_ep]]) begin
							txl_reg   <= len_reg[tok_ep][usbb_reg[tok_ep]];
							state_reg <= S_TX;
						end else if ((tok_kind == TK_OUT && out_ok)
							|| (tok_kind == TK_SETUP && ep_en && is_ctrl)) begin
							state_reg <= S_RX;
						end
					end
				end
				S_RX: begin
					if (rx_valid && rxt_reg != '1) begin
						rxt_reg <= rxt_reg + CNTW'(1);
					end
					if (rx_store) begin
						rxs_reg <= rxs_reg + LENW'(1);
					end
					if (rx_end) begin
						state_reg <= S_IDLE;
					end
				end
				S_TX: begin
					txi_reg <= txi_reg + LENW'(1);
					if (txl_reg == '0 || txi_reg == txl_reg - LENW'(1)) begin
						state_reg <= S_ACKW;
					end
				end
				S_ACKW: begin
					// A new token means the host gave up; bank stays for retry
					if (host_ack || tok_valid) begin
						state_reg <= S_IDLE;
					end
				end
				default: state_reg <= S_IDLE;
			endcase
		end
	end

	// Link outputs, registered
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			tx_valid <= 1'b0;
			tx_data  <= 8'h00;
			tx_last  <= 1'b0;
			tx_zlp   <= 1'b0;
			hs_ack   <= 1'b0;
			hs_nak   <= 1'b0;
		end else if (ce) begin
			tx_valid <= (state_reg == S_TX) && txl_reg != '0;
			tx_data  <= fifo_mem[fidx(cep_reg, usbb_reg[cep_reg], txi_reg)];
			tx_last  <= (state_reg == S_TX) && txl_reg != '0
				&& txi_reg == txl_reg - LENW'(1);
			tx_zlp   <= (state_reg == S_TX) && txl_reg == '0;
			hs_ack   <= ev_setup | ev_out;
			// Iso endpoints never handshake
			hs_nak   <= (state_reg == S_IDLE && tok_valid && tok_kind == TK_IN && in_ok
				&& !full_reg[tok_ep][usbb_reg[tok_ep]]
				&& ctrl_reg[tok_ep][1:0] != TY_ISO)
				|| ((state_reg == S_RX) && rx_end && ckind_reg == TK_OUT
				&& !is_iso && nakp_reg && rx_crc_ok);  // Corrupt packet stays silent
		end
	end
endmodule : uetc_core

// file: sim/uetc_monitor.sv
// Checker for the endpoint transaction block, bound to its top module.
// Assumes one clock domain and ce held high while traffic runs.
`timescale 1ns/10ps
module uetc_monitor import uetc_pkg::*; (
	input wire logic       hclk,
	input wire logic       hresetn,
	input wire logic       ce,
	input wire logic       hreadyout,
	input wire logic       tok_valid,
	input wire logic [1:0] tok_kind,
	input wire logic       rx_end,
	input wire logic       rx_crc_ok,
	input wire logic       tx_valid,
	input wire logic       tx_last,
	input wire logic       tx_zlp,
	input wire logic       hs_ack,
	input wire logic       hs_nak
);
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	// Bus never stalls while the block runs
	ready_tracks_ce_a: assert property (hreadyout == ce)
		else $error("hreadyout differs from ce");
	// A NAK always answers a token or a packet end
	nak_cause_a: assert property (hs_nak |-> $past(tok_valid) || $past(rx_end))
		else $error("NAK without a cause");
	// Final byte flag only inside a data burst
	last_in_burst_a: assert property (tx_last |-> tx_valid)
		else $error("tx_last outside data");
	// Bytes leave back to back until the last one
	burst_solid_a: assert property (tx_valid && !tx_last |=> tx_valid)
		else $error("gap in IN data");
	// Data starts two edges after an IN token
	burst_start_a: assert property ($rose(tx_valid) |->
		$past(tok_valid, 2) && $past(tok_kind, 2) == TK_IN)
		else $error("IN data without IN token");
	// Empty packet also two edges after the token
	zlp_start_a: assert property (tx_zlp |-> $past(tok_valid, 2) && !tx_valid)
		else $error("zero-length packet misplaced");
	// Empty packet is a single pulse with no data after it
	zlp_single_a: assert property (tx_zlp |=> !tx_zlp && !tx_valid)
		else $error("zero-length packet repeated");
	// ACK only after a packet with good CRC
	ack_cause_a: assert property (hs_ack |-> $past(rx_end) && $past(rx_crc_ok))
		else $error("ACK without good packet");
	// A corrupt packet gets no handshake at all
	bad_crc_quiet_a: assert property (rx_end && !rx_crc_ok |=> !hs_ack && !hs_nak)
		else $error("handshake after bad CRC");
	// Only one kind of answer at a time
	one_reply_a: assert property ($onehot0({hs_ack, hs_nak, tx_valid, tx_zlp}))
		else $error("two answers at once");
	cover property (tx_last);
	cover property (tx_zlp);
	cover property (hs_nak);
	cover property (hs_ack);
endmodule : uetc_monitor

bind uetc_core uetc_monitor uetc_monitor_inst (.hclk, .hresetn, .ce, .hreadyout, .tok_valid,
	.tok_kind, .rx_end, .rx_crc_ok, .tx_valid, .tx_last, .tx_zlp, .hs_ack, .hs_nak);

// file: sim/uetc_host.sv
// Host-side model: sends tokens and OUT packets, acknowledges IN data.
// Assumes the block's link ports on the shared bus clock.
`timescale 1ns/10ps
module uetc_host import uetc_pkg::*; (
	input  wire logic      hclk,
	input  wire logic      tx_last,
	input  wire logic      tx_zlp,
	output logic           tok_valid,
	output logic [1:0]     tok_kind,
	output logic [EPW-1:0] tok_ep,
	output logic           rx_valid,
	output logic [7:0]     rx_data,
	output logic           rx_end,
	output logic           rx_crc_ok,
	output logic           host_ack
);
	logic [7:0] byte_reg;    // Last byte on the line
	logic       crc_reg;     // CRC verdict of this packet
	int         ack_dly = 0; // Reply delay, raised for a slow host
	// Idle lines show the inverse, so a stale value never looks valid
	assign rx_data   = rx_valid ? byte_reg : ~byte_reg;
	assign rx_crc_ok = rx_end ? crc_reg : ~crc_reg;
	initial begin
		tok_valid = 1'b0;
		tok_kind  = 2'h0;
		tok_ep    = '0;
		rx_valid  = 1'b0;
		rx_end    = 1'b0;
		host_ack  = 1'b0;
		byte_reg  = 8'h00;
		crc_reg   = 1'b0;
	end
	// One-cycle token pulse
	task token(input logic [1:0] k, input logic [EPW-1:0] e);
		tok_valid <= 1'b1;
		tok_kind  <= k;
		tok_ep    <= e;
		@(posedge hclk);
		tok_valid <= 1'b0;
	endtask : token
	// OUT or SETUP packet, bytes counting up from 0x10
	task send(input logic [1:0] k, input logic [EPW-1:0] e, input int n, input logic c);
		token(k, e);
		for (int i = 0; i < n; i++) begin
			rx_valid <= 1'b1;
			byte_reg <= 8'h10 + i[7:0];
			@(posedge hclk);
		end
		rx_valid <= 1'b0;
		rx_end   <= 1'b1;
		crc_reg  <= c;
		@(posedge hclk);
		rx_end <= 1'b0;
		@(posedge hclk); // Spacing the block needs before a token
	endtask : send
	// Acknowledge every IN packet after the chosen delay
	always @(posedge hclk) begin
		if (tx_last || tx_zlp) begin
			repeat (ack_dly) @(posedge hclk);
			host_ack <= 1'b1;
			@(posedge hclk);
			host_ack <= 1'b0;
		end
	end
endmodule : uetc_host

// file: sim/testbench.sv
// Self-checking bench: AHB-Lite firmware tasks plus a host model.
// Assumes ce stays high, so every bus access has zero wait states.
`timescale 1ns/10ps
module testbench import uetc_pkg::*;;
	logic           hclk, hresetn, ce, hsel, hwrite, hready, hreadyout, hresp;
	logic [1:0]     htrans, tok_kind;
	logic [2:0]     hsize;
	logic [31:0]    haddr, hwdata, hrdata;
	logic           tok_valid, rx_valid, rx_end, rx_crc_ok, host_ack;
	logic [EPW-1:0] tok_ep;
	logic [7:0]     rx_data, tx_data;
	logic           tx_valid, tx_last, tx_zlp, hs_ack, hs_nak;
	int             n_errors, n_checks, n_nak, n_zlp, n_ack;
	bit             acked;  // Host acknowledged IN data
	logic [7:0]     txq[$]; // Bytes seen on the link
	assign hready = hreadyout;
	always #50 hclk = ~hclk;
	uetc_core uetc_core_inst (.hclk, .hresetn, .ce, .hsel, .haddr, .htrans, .hwrite, .hsize,
		.hwdata, .hready, .hreadyout, .hresp, .hrdata, .tok_valid, .tok_kind, .tok_ep, .rx_valid,
		.rx_data, .rx_end, .rx_crc_ok, .host_ack, .tx_valid, .tx_data, .tx_last, .tx_zlp,
		.hs_ack, .hs_nak);
	uetc_host uetc_host_inst (.hclk, .tx_last, .tx_zlp, .tok_valid, .tok_kind, .tok_ep,
		.rx_valid, .rx_data, .rx_end, .rx_crc_ok, .host_ack);
	// Collect link answers
	always @(posedge hclk) begin
		if (tx_valid === 1'b1) txq.push_back(tx_data);
		if (tx_zlp === 1'b1) n_zlp++;
		if (hs_nak === 1'b1) n_nak++;
		if (hs_ack === 1'b1) n_ack++;
		if (host_ack === 1'b1) acked = 1;
	end
	task print_verdict;
		$display("checks %0d errors %0d", n_checks, n_errors);
		if (n_errors == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	task tmo;
		n_errors++;
		print_verdict();
	endtask : tmo
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e) begin
			n_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// Bounded wait for hready at a rising edge
	task wt;
		int i;
		i = 0;
		do begin @(posedge hclk); i++; end while (hready !== 1'b1 && i < 40);
		if (hready !== 1'b1) tmo();
	endtask : wt
	// One single transfer: address phase, then data phase
	task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		hsel   <= 1'b1;
		htrans <= HTRANS_NONSEQ;
		haddr  <= {24'h0, a};
		hwrite <= w;
		wt();
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		wt();
		q = hrdata;
		chk("hresp", 32'h0, {31'h0, hresp});
	endtask : bus
	task wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		bus(1'b1, a, {24'h0, d}, q);
	endtask : wr
	task rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(nm, {24'h0, e}, {24'h0, q[7:0]});
	endtask : rdc
	// Expect n bytes counting up from b, then forget them
	task txchk(input logic [7:0] b, input int n);
		chk("tx count", n, txq.size());
		foreach (txq[i]) chk("tx byte", b + i, txq[i]);
		txq.delete();
	endtask : txchk
	// IN token, wait for NAK or host ACK
	task in_x(input logic [EPW-1:0] e);
		int i, k;
		k = n_nak;
		acked = 0;
		uetc_host_inst.token(TK_IN, e);
		for (i = 0; i < 80 && n_nak == k && !acked; i++) @(posedge hclk);
		if (i == 80) tmo();
		@(posedge hclk);
	endtask : in_x
	task s_ctrl;
		wr(OFF_SEL, 8'h00);
		rdc(OFF_CTRL, CTRL_EP0_RST, "ctrl ep0");
		wr(OFF_STAT, 8'h8f);
		wr(OFF_DATA, 8'h44);
		wr(OFF_STAT, 8'h9f);
		in_x(2'd0);
		txchk(8'h44, 1);
		uetc_host_inst.send(TK_SETUP, 2'd0, 8, 1'b1);
		rdc(OFF_STAT, 8'h04, "stat setup");
		rdc(OFF_BCL, 8'h08, "bcl setup");
		rdc(OFF_DATA, 8'h10, "setup byte");
		wr(OFF_STAT, 8'h0b);
		uetc_host_inst.send(TK_OUT, 2'd0, 0, 1'b1);
		rdc(OFF_STAT, 8'h02, "stat status out");
		rdc(OFF_BCL, 8'h00, "bcl zlp");
		chk("acks", 2, n_ack);
		// Corrupt OUT while the bank is still held: no ACK and no NAK
		uetc_host_inst.send(TK_OUT, 2'd0, 1, 1'b0);
		chk("naks bad crc", 0, n_nak);
		chk("acks bad crc", 2, n_ack);
	endtask : s_ctrl
	task s_single;
		wr(OFF_SEL, 8'h01);
		wr(OFF_CTRL, 8'h86);
		in_x(2'd1);
		chk("naks", 1, n_nak);
		for (int i = 0; i < 3; i++) wr(OFF_DATA, 8'ha0 + i[7:0]);
		rdc(OFF_BCL, 8'h00, "bcl after load");
		wr(OFF_STAT, 8'h1f);
		in_x(2'd1);
		txchk(8'ha0, 3);
		rdc(OFF_STAT, 8'h01, "stat sent");
	endtask : s_single
	task s_zlp;
		wr(OFF_STAT, 8'h0e);
		wr(OFF_STAT, 8'h1f);
		in_x(2'd1);
		chk("zlps", 1, n_zlp);
		txchk(8'h00, 0);
		wr(OFF_STAT, 8'h0e);
		wr(OFF_DATA, 8'h55);
		wr(OFF_DATA, 8'h66);
		wr(OFF_STAT, 8'h1f);
		wr(OFF_STAT, 8'h0f);
		in_x(2'd1);
		chk("naks", 2, n_nak);
		wr(OFF_DATA, 8'h77);
		wr(OFF_STAT, 8'h1f);
		in_x(2'd1);
		txchk(8'h77, 1);
	endtask : s_zlp
	task s_pp;
		wr(OFF_SEL, 8'h02);
		wr(OFF_CTRL, 8'h8e);
		wr(OFF_DATA, 8'h31);
		wr(OFF_STAT, 8'h1f);
		wr(OFF_DATA, 8'h32);
		wr(OFF_STAT, 8'h1f);
		uetc_host_inst.ack_dly = 3;
		in_x(2'd2);
		wr(OFF_STAT, 8'h0e);
		in_x(2'd2);
		txchk(8'h31, 2);
		wr(OFF_STAT, 8'h0e);
		in_x(2'd2);
		chk("naks", 3, n_nak);
		uetc_host_inst.ack_dly = 0;
	endtask : s_pp
	task s_iso;
		wr(OFF_SEL, 8'h03);
		wr(OFF_CTRL, 8'h81);
		uetc_host_inst.send(TK_OUT, 2'd3, 40, 1'b1);
		rdc(OFF_STAT, 8'h02, "iso stat");
		rdc(OFF_BCL, 8'h28, "iso bcl");
		rdc(OFF_BCH, 8'h00, "iso bch");
		rdc(OFF_DATA, 8'h10, "iso byte0");
		uetc_host_inst.send(TK_OUT, 2'd3, 3, 1'b1);
		rdc(OFF_BCL, 8'h28, "iso bcl kept");
		uetc_host_inst.token(TK_IN, 2'd3);
		wr(OFF_STAT, 8'h0d);
		chk("naks", 3, n_nak);
		uetc_host_inst.send(TK_OUT, 2'd3, 0, 1'b0);
		rdc(OFF_STAT, 8'h0a, "iso crc stat");
		rdc(OFF_BCL, 8'h00, "iso bcl zlp");
		rdc(8'h18, 8'h00, "unmapped");
		chk("acks", 2, n_ack);
	endtask : s_iso
	// Hang guard
	initial begin
		repeat (20000) @(posedge hclk);
		tmo();
	end
	initial begin
		hclk     = 1'b0;
		hresetn  = 1'b0;
		ce       = 1'b1;
		hsel     = 1'b0;
		hwrite   = 1'b0;
		htrans   = 2'h0;
		hsize    = 3'h2;
		haddr    = 32'h0;
		hwdata   = 32'h0;
		n_errors = 0;
		n_checks = 0;
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		s_ctrl();
		s_single();
		s_zlp();
		s_pp();
		s_iso();
		print_verdict();
	end
endmodule : testbench
